// ==== logic/strap_cfg_pkg.sv ====
// Constants, types and state records for strap configuration and reference select
package strap_cfg_pkg;

   // Timing of each probe step
   localparam int CLK_PERIOD_NS = 40;
   localparam int SETTLE_NS     = 200;
   localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W         = 16;

   // Probe drive: four config outputs, three steps, one pattern per output
   localparam int          N_CFG_OUT  = 4;
   localparam int          N_STEPS    = 3;
   // Bit 3k+s drives output k in step s: out0 001, out1 100, out2 010, out3 (ref_fail_alarm) 011
   // Every output needs its own history, or two wirings would decode alike
   localparam logic [11:0] PROBE_PATS = 12'h6a1;
   localparam logic [2:0]  PAT_LOW    = 3'h0;
   localparam logic [2:0]  PAT_HIGH   = 3'h7;

   // Strap classes
   localparam logic [2:0] TIE_LOW    = 3'h0;
   localparam logic [2:0] TIE_HIGH   = 3'h1;
   localparam logic [2:0] TIE_OUT0   = 3'h2;
   localparam logic [5:0] STRAP_KINDS = 6'h06;

   // Field positions of the combined strap code
   localparam int DIV_LSB  = 0;
   localparam int DIV_W    = 3;
   localparam int LOCK_BIT = 3;
   localparam int PAD_BIT  = 4;

   typedef struct packed {
      logic [3:0] odd_div;
      logic       lock_en;
      logic       pad_ecl;
   } strap_cfg_t;

   localparam strap_cfg_t CFG_RESET = '{odd_div: 4'h1, lock_en: 1'b0, pad_ecl: 1'b0};

   typedef enum logic [1:0] {
      ST_WAIT  = 2'b00,
      ST_PROBE = 2'b01,
      ST_LATCH = 2'b11,
      ST_RUN   = 2'b10
   } cfg_state_t;

   typedef struct packed {
      cfg_state_t       st;
      logic [1:0]       step;
      logic [CNT_W-1:0] cnt;
      logic [3:0]       pins;
      strap_cfg_t       cfg;
      logic             ref_b;
      logic             auto_mode;
      logic             lock;
   } ctrl_state_t;

   localparam ctrl_state_t CTRL_RESET = '{st: ST_WAIT, step: 2'h0, cnt: '0, pins: 4'h0,
                                          cfg: CFG_RESET, ref_b: 1'b0, auto_mode: 1'b0, lock: 1'b0};

   typedef struct packed {
      logic [N_STEPS-1:0] hist;
   } probe_state_t;

endpackage

// ==== logic/strap_probe_decoder.sv ====
// Classifies one strap input as tied low, tied high or joined to a config output
`timescale 1ns/1ps
module strap_probe_decoder
   import strap_cfg_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   input  wire logic       ce,
   input  wire logic       clear,
   input  wire logic       sample,
   input  wire logic       pin,
   output logic [2:0]      tie
);
   import strap_cfg_pkg::*;

   probe_state_t state;
   probe_state_t next_state;

   always_comb begin
      next_state = state;
      if (clear) begin
         next_state.hist = '0;
      end else if (sample) begin
         // Oldest step ends in bit 0 after the last shift
         next_state.hist = {pin, state.hist[N_STEPS-1:1]};
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state <= '0;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // Illegal histories fall back to low, the pull-down default
   always_comb begin
      tie = TIE_LOW;
      if (state.hist == PAT_HIGH) begin
         tie = TIE_HIGH;
      end
      for (int k = 0; k < N_CFG_OUT; k++) begin
         if (state.hist == PROBE_PATS[3*k +: 3]) begin
            tie = TIE_OUT0 + 3'(k);
         end
      end
   end

endmodule

// ==== logic/strap_config_and_ref_select.sv ====
// Strap probing, configuration latch and reference clock selection
// Operation
// - Straps are probed after power-up and again after every reset.
// - Each strap is classed as low, high, or tied to a config output.
// - Last strap pair picks an odd output divider from one to fifteen.
// - Same pair enables or disables the lock indicator.
// - Same pair picks current-mode or emitter-coupled pads for outputs c and d.
// - Manual mode: choose high selects reference b, low selects reference a.
// - Automatic-select high with choose low requests automatic switching.
// - Lock indicator stays low while the lock detector is disabled.
// - Outside probing, alarm is high while the selected reference has failed, else low.
`timescale 1ns/1ps
module strap_config_and_ref_select
   import strap_cfg_pkg::*;
#(
   parameter int SETTLE = SETTLE_CYC
)
(
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   input  wire logic       ce,
   input  wire logic       sys_reset_n,
   input  wire logic       strap_input_g,
   input  wire logic       strap_input_h,
   input  wire logic       ref_b_choose,
   input  wire logic       auto_sel,
   input  wire logic       ref_a_fail,
   input  wire logic       ref_b_fail,
   input  wire logic       lock_raw,
   output logic [2:0]      cfg_out,
   output logic            ref_fail_alarm,
   output strap_cfg_pkg::strap_cfg_t strap_cfg,
   output logic            config_done,
   output logic            ref_b_selected,
   output logic            auto_mode,
   output logic            lock_indicator
);
   import strap_cfg_pkg::*;

   if (SETTLE < 1 || SETTLE >= (1 << CNT_W)) begin : g_bad_settle
      $error("SETTLE out of range");
   end

   ctrl_state_t state;
   ctrl_state_t next_state;
   logic        sample;
   logic        clear;
   logic [2:0]  tie_g;
   logic [2:0]  tie_h;
   logic [5:0]  code;
   logic        sel_fail;
   logic        other_fail;
   logic        auto_req;
   strap_cfg_t  decoded;

   strap_probe_decoder u_dec_g (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .ce      (ce),
      .clear   (clear),
      .sample  (sample),
      .pin     (strap_input_g),
      .tie     (tie_g)
   );

   strap_probe_decoder u_dec_h (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .ce      (ce),
      .clear   (clear),
      .sample  (sample),
      .pin     (strap_input_h),
      .tie     (tie_h)
   );

   function automatic logic [3:0] probe_drive(input logic [1:0] step);
      logic [3:0] d;
      d = '0;
      for (int k = 0; k < N_CFG_OUT; k++) begin
         d[k] = PROBE_PATS[3*k + int'(step)];
      end
      return d;
   endfunction

   assign sample   = (state.st == ST_PROBE) && (state.cnt == CNT_W'(SETTLE - 1));
   assign clear    = (state.st == ST_WAIT);
   assign auto_req = auto_sel && !ref_b_choose;
   assign sel_fail = state.ref_b ? ref_b_fail : ref_a_fail;
   // Standby reference health; a switch onto a dead clock would gain nothing
   assign other_fail = state.ref_b ? ref_a_fail : ref_b_fail;

   // Six classes per strap give 36 codes; the low bits set the divider
   always_comb begin
      code            = 6'(tie_g) * STRAP_KINDS + 6'(tie_h);
      decoded.odd_div = {code[DIV_LSB +: DIV_W], 1'b1};
      decoded.lock_en = ~code[LOCK_BIT];
      decoded.pad_ecl = code[PAD_BIT];
   end

   always_comb begin
      next_state = state;
      unique case (state.st)
         ST_WAIT: begin
            next_state.cnt  = '0;
            next_state.step = 2'h0;
            if (sys_reset_n) begin
               next_state.st = ST_PROBE;
            end
         end
         ST_PROBE: begin
            next_state.cnt = state.cnt + CNT_W'(1);
            if (sample) begin
               next_state.cnt  = '0;
               next_state.step = state.step + 2'h1;
               if (state.step == 2'(N_STEPS - 1)) begin
                  next_state.st = ST_LATCH;
               end
            end
         end
         ST_LATCH: begin
            next_state.cfg = decoded;
            next_state.st  = ST_RUN;
         end
         ST_RUN: begin
            next_state.st = ST_RUN;
         end
      endcase
      if (!sys_reset_n) begin
         next_state.st = ST_WAIT;
         next_state.cfg = CFG_RESET;
      end

      // Probe patterns only while probing; the alarm pin doubles as output 3
      if (next_state.st == ST_PROBE) begin
         next_state.pins = probe_drive(next_state.step);
      end else begin
         next_state.pins = {sel_fail, 3'h0};
      end

      next_state.auto_mode = auto_req;
      if (!auto_req) begin
         next_state.ref_b = ref_b_choose;
      end else if (sel_fail && !other_fail) begin
         // Non-revertive: stay on the new reference once moved
         next_state.ref_b = ~state.ref_b;
      end
      // Gated by the next enable, so the pin never lags a disable
      next_state.lock = next_state.cfg.lock_en && lock_raw;
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state <= CTRL_RESET;
      end else if (ce) begin
         state <= next_state;
      end
   end

   assign cfg_out        = state.pins[2:0];
   assign ref_fail_alarm = state.pins[3];
   assign strap_cfg      = state.cfg;
   assign config_done    = (state.st == ST_RUN);
   assign ref_b_selected = state.ref_b;
   assign auto_mode      = state.auto_mode;
   assign lock_indicator = state.lock;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence s_released;
      ce && state.st == ST_WAIT && sys_reset_n;
   endsequence
   sequence s_probing;
      state.st == ST_PROBE && cfg_out == 3'(probe_drive(2'h0));
   endsequence

   a_probe_after_release: assert property (s_released |=> s_probing)
      else $error("probe did not start after reset release");
   a_reset_restarts: assert property (ce && !sys_reset_n |=> state.st == ST_WAIT)
      else $error("reset did not restart configuration");
   a_latch_decode: assert property (ce && state.st == ST_LATCH && sys_reset_n |=> strap_cfg == $past(decoded))
      else $error("strap decode not latched");
   a_divider_odd: assert property (strap_cfg.odd_div[0] == 1'b1)
      else $error("output divider is even");
   a_lock_gate: assert property (ce && state.st == ST_LATCH && sys_reset_n
                                 |=> strap_cfg.lock_en == !$past(code[LOCK_BIT]))
      else $error("lock enable decode wrong");
   a_pad_mode: assert property (ce && state.st == ST_LATCH && sys_reset_n
                                |=> strap_cfg.pad_ecl == $past(code[PAD_BIT]))
      else $error("pad mode decode wrong");
   a_manual_pick: assert property (ce && !auto_req |=> ref_b_selected == $past(ref_b_choose))
      else $error("manual reference select wrong");
   a_auto_entry: assert property (ce |=> auto_mode == $past(auto_req))
      else $error("automatic mode request not followed");
   a_lock_held_low: assert property (!strap_cfg.lock_en |=> !lock_indicator)
      else $error("lock indicator high while disabled");
   a_alarm_follows: assert property (ce && state.st != ST_WAIT && sys_reset_n
                                     && next_state.st != ST_PROBE |=> ref_fail_alarm == $past(sel_fail))
      else $error("alarm does not follow selected reference");
   a_cfg_frozen: assert property (state.st == ST_RUN && sys_reset_n |=> $stable(strap_cfg))
      else $error("configuration changed after latch");
   a_done_after_latch: assert property (ce && sys_reset_n && state.st == ST_LATCH |=> config_done)
      else $error("configuration not reported done after latch");
   a_latch_after_probe: assert property (ce && sys_reset_n && sample
                                         && state.step == 2'(N_STEPS - 1) |=> state.st == ST_LATCH)
      else $error("latch did not follow the last probe step");
   a_cfg_out_idle: assert property (ce && next_state.st != ST_PROBE |=> cfg_out == 3'h0)
      else $error("config outputs not idle outside probing");
   a_lock_follows: assert property (ce && sys_reset_n && state.st == ST_RUN
                                    |=> lock_indicator == ($past(lock_raw) && strap_cfg.lock_en))
      else $error("lock indicator does not follow enabled lock");

   // Automatic mode moves only when the standby reference is healthy
   sequence s_sel_lost;
      ce && auto_req && sel_fail && !other_fail;
   endsequence
   sequence s_sel_kept;
      ce && auto_req && !(sel_fail && !other_fail);
   endsequence

   a_auto_switch: assert property (s_sel_lost |=> ref_b_selected != $past(ref_b_selected))
      else $error("automatic mode did not leave failed reference");
   a_auto_hold: assert property (s_sel_kept |=> ref_b_selected == $past(ref_b_selected))
      else $error("automatic mode moved without cause");

endmodule

// ==== verif/strap_board_model.sv ====
// Board strap wiring: each strap tied low, high or to one config output
`timescale 1ns/1ps
module strap_board_model (
   input  wire logic [2:0] cfg_out,
   input  wire logic       ref_fail_alarm,
   input  wire logic [2:0] sel_g,
   input  wire logic [2:0] sel_h,
   output logic            strap_input_g,
   output logic            strap_input_h
);
   // Class 0 low, 1 high, 2+k joined to config output k
   function automatic logic wire_of(input logic [2:0] s, input logic [3:0] p);
      if (s == 3'h0) begin
         return 1'b0;
      end
      if (s == 3'h1) begin
         return 1'b1;
      end
      return p[2'(s - 3'h2)];
   endfunction
   // A strap joined to an output follows it at once, like a copper trace
   assign strap_input_g = wire_of(sel_g, {ref_fail_alarm, cfg_out});
   assign strap_input_h = wire_of(sel_h, {ref_fail_alarm, cfg_out});
endmodule

// ==== verif/strap_config_and_ref_select_test.sv ====
// Self-checking bench for strap configuration and reference select
`timescale 1ns/1ps
module strap_config_and_ref_select_test;
   import strap_cfg_pkg::*;
   logic       clk_sys = 1'b0, sys_rst = 1'b1, sys_reset_n = 1'b1, ref_b_choose = 1'b0, auto_sel = 1'b0;
   logic       ref_a_fail = 1'b0, ref_b_fail = 1'b0, lock_raw = 1'b0, ce = 1'b1;
   logic [2:0] sel_g = 3'h1, sel_h = 3'h1, cfg_out;
   logic       strap_input_g, strap_input_h, ref_fail_alarm, config_done, ref_b_selected, auto_mode, lock_indicator;
   strap_cfg_t strap_cfg, e;
   int         n_mismatch = 0, n_tests = 0, cyc = 0;
   // Class pairs reach every divider, every class, both lock and pad settings
   logic [2:0] tg [11] = '{3'h1, 3'h0, 3'h0, 3'h0, 3'h1, 3'h4, 3'h0, 3'h2, 3'h4, 3'h3, 3'h5};
   logic [2:0] th [11] = '{3'h1, 3'h0, 3'h1, 3'h2, 3'h5, 3'h5, 3'h4, 3'h0, 3'h4, 3'h4, 3'h3};

   always #20 clk_sys = ~clk_sys;

   strap_config_and_ref_select #(.SETTLE(2)) u_strap_config_and_ref_select (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .sys_reset_n(sys_reset_n),
      .strap_input_g(strap_input_g), .strap_input_h(strap_input_h), .ref_b_choose(ref_b_choose),
      .auto_sel(auto_sel), .ref_a_fail(ref_a_fail), .ref_b_fail(ref_b_fail), .lock_raw(lock_raw),
      .cfg_out(cfg_out), .ref_fail_alarm(ref_fail_alarm), .strap_cfg(strap_cfg), .config_done(config_done),
      .ref_b_selected(ref_b_selected), .auto_mode(auto_mode), .lock_indicator(lock_indicator));

   strap_board_model u_strap_board_model (
      .cfg_out(cfg_out), .ref_fail_alarm(ref_fail_alarm), .sel_g(sel_g), .sel_h(sel_h),
      .strap_input_g(strap_input_g), .strap_input_h(strap_input_h));

   task chk(input string nm, input logic [5:0] ex, input logic [5:0] got);
      n_tests++;
      if (got !== ex) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task results;
      $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Whole run is well under 1000 cycles
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         results();
      end
   end

   task step(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask

   function automatic strap_cfg_t exp_cfg(input logic [2:0] g, input logic [2:0] h);
      logic [4:0] c;
      c = 5'(g * 6 + h);
      return '{odd_div: {c[2:0], 1'b1}, lock_en: ~c[3], pad_ecl: c[4]};
   endfunction

   task wait_done;
      for (int i = 0; i < 100 && config_done !== 1'b1; i++) step(1);
      chk("config_done", 6'h01, 6'(config_done));
   endtask

   task reconfig(input logic [2:0] g, input logic [2:0] h);
      sel_g = g;
      sel_h = h;
      sys_reset_n = 1'b0;
      step(2);
      chk("config_done low", 6'h00, 6'(config_done));
      chk("strap_cfg in reset", 6'(CFG_RESET), 6'(strap_cfg));
      sys_reset_n = 1'b1;
      step(1);
      wait_done();
      chk("strap_cfg", 6'(exp_cfg(g, h)), 6'(strap_cfg));
      chk("cfg_out idle", 6'h00, 6'(cfg_out));
   endtask

   initial begin
      step(3);
      sys_rst = 1'b0;
      wait_done();
      chk("strap_cfg power-up", 6'(exp_cfg(3'h1, 3'h1)), 6'(strap_cfg));
      for (int i = 0; i < 11; i++) begin
         reconfig(tg[i], th[i]);
         e = exp_cfg(tg[i], th[i]);
         lock_raw = 1'b1;
         step(2);
         chk("lock_indicator", 6'(e.lock_en), 6'(lock_indicator));
         lock_raw = 1'b0;
      end
      // Strap moves after the latch must not leak through
      sel_g = 3'h1;
      sel_h = 3'h0;
      step(8);
      chk("strap_cfg held", 6'(e), 6'(strap_cfg));
      for (int b = 1; b >= 0; b--) begin
         ref_b_choose = b[0];
         for (int j = 0; j < 4; j++) begin
            {ref_b_fail, ref_a_fail} = j[1:0];
            step(2);
            chk("ref_b_selected", 6'(b[0]), 6'(ref_b_selected));
            chk("auto_mode manual", 6'h00, 6'(auto_mode));
            chk("ref_fail_alarm", 6'(b[0] ? j[1] : j[0]), 6'(ref_fail_alarm));
         end
      end
      // Clock enable low must freeze the selection
      ce = 1'b0;
      ref_b_choose = 1'b1;
      step(3);
      chk("ref_b_selected frozen", 6'h00, 6'(ref_b_selected));
      ce = 1'b1;
      step(2);
      chk("ref_b_selected after enable", 6'h01, 6'(ref_b_selected));
      ref_b_choose = 1'b0;
      step(2);
      chk("ref_b_selected back to a", 6'h00, 6'(ref_b_selected));
      {ref_b_fail, ref_a_fail} = 2'b00;
      auto_sel = 1'b1;
      step(2);
      chk("auto_mode", 6'h01, 6'(auto_mode));
      ref_a_fail = 1'b1;
      step(3);
      chk("auto switch to b", 6'h01, 6'(ref_b_selected));
      chk("alarm after switch", 6'h00, 6'(ref_fail_alarm));
      ref_a_fail = 1'b0;
      ref_b_fail = 1'b1;
      step(3);
      chk("auto switch back to a", 6'h00, 6'(ref_b_selected));
      chk("alarm after switch back", 6'h00, 6'(ref_fail_alarm));
      results();
   end
endmodule
